//--- verilog/adcsq_defines.vh
// Constants and register map of the converter sequencing and result FIFO block.
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

`define ADCSQ_CLK_MHZ          160
`define ADCSQ_WAIT_NS          1600
`define ADCSQ_WAIT_CYC         ((`ADCSQ_WAIT_NS * `ADCSQ_CLK_MHZ) / 1000)
`define ADCSQ_WAKE_NS          5000
`define ADCSQ_WAKE_CYC         ((`ADCSQ_WAKE_NS * `ADCSQ_CLK_MHZ) / 1000)
`define ADCSQ_CAL_CYC          64
`define ADCSQ_GLOB_GAP         5
`define ADCSQ_CONV_CYC         8

`define ADCSQ_A_ANCFG          12'h000
`define ADCSQ_A_ARBCFG         12'h004
`define ADCSQ_A_GLOBAL_CONFIG_REGISTER        12'h008
`define ADCSQ_A_BWCFG          12'h00C
`define ADCSQ_A_STATUS         12'h010
`define ADCSQ_A_IRQ_STAT       12'h014
`define ADCSQ_A_IRQ_MASK       12'h018
`define ADCSQ_A_FIFO           12'h01C
`define ADCSQ_A_SHARED_RESULT_REGISTER        12'h020
`define ADCSQ_A_SAMPLE         12'h024

`define ADCSQ_ANCFG_IPE        0
`define ADCSQ_ANCFG_SLOW       1
`define ADCSQ_ARBCFG_EN        0
`define ADCSQ_GLOBAL_CONFIG_REGISTER_CAL      31
`define ADCSQ_BW_EN            0
`define ADCSQ_BW_REF           1
`define ADCSQ_BW_THR_LSB       4

`define ADCSQ_IRQ_RES          0
`define ADCSQ_IRQ_OVR          1
`define ADCSQ_IRQ_DROP         2
`define ADCSQ_IRQ_BW           3
`define ADCSQ_IRQ_CAL          4
`define ADCSQ_IRQ_W            5

`define ADCSQ_FIFO_DEPTH       4
`define ADCSQ_RES_W            12
`endif

//--- verilog/adcsq_fifo.v
// Result FIFO built from chained result stages with a registered output.
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_fifo
(
   input  wire                     pclk,
   input  wire                     presetn,
   input  wire                     wr,
   input  wire [`ADCSQ_RES_W-1:0]  wdata,
   input  wire                     rd,
   output reg  [`ADCSQ_RES_W-1:0]  rdata,
   output reg                      out_valid,
   output reg                      overwrite,
   output reg                      dropped
);
   localparam D = `ADCSQ_FIFO_DEPTH;
   wire [`ADCSQ_RES_W-1:0] data_w [0:D-1];
   wire [D-1:0]            full_w;
   wire [D-1:0]            vacate;
   // Stage 0 is the output, stage D-1 the uppermost stage.
   // Stage 0 empties on a read; the read only comes while it holds data.
   assign vacate[0] = rd;
   genvar i;
   generate
      for (i = 0; i < D; i = i + 1)
      begin : g_stage
         reg                     full_q;
         reg [`ADCSQ_RES_W-1:0]  data_q;
         wire                    load;
         wire [`ADCSQ_RES_W-1:0] src;
         if (i == D-1)
         begin : g_top
            // A write while the top stage moves down is lost.
            assign load = wr & ~vacate[i];
            assign src  = wdata;
         end
         else
         begin : g_mid
            assign load = vacate[i+1];
            assign src  = data_w[i+1];
         end
         if (i > 0)
         begin : g_move
            // A stage copies down when the stage below is free or empties now.
            assign vacate[i] = full_q & (~full_w[i-1] | vacate[i-1]);
         end
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               full_q <= 1'b0;
               data_q <= {`ADCSQ_RES_W{1'b0}};
            end
            else if (load)
            begin
               full_q <= 1'b1;
               data_q <= src;
            end
            else if (vacate[i])
               full_q <= 1'b0;
         end
         assign full_w[i] = full_q;
         assign data_w[i] = data_q;
      end
   endgenerate
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overwrite <= 1'b0;
         dropped   <= 1'b0;
      end
      else
      begin
         overwrite <= wr & full_w[D-1] & ~vacate[D-1];
         dropped   <= wr & vacate[D-1];
      end
   end
   always @*
   begin
      rdata     = data_w[0];
      out_valid = full_w[0];
   end
endmodule

//--- verilog/adcsq_top.v
// Converter sequencing control with APB registers, result FIFO and interrupt.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_top
#(
   parameter WAKE_CYC = `ADCSQ_WAKE_CYC,
   parameter CAL_CYC  = `ADCSQ_CAL_CYC
)
(
   input  wire                     pclk,
   input  wire                     presetn,
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [11:0]              paddr,
   input  wire [31:0]              pwdata,
   output reg  [31:0]              prdata,
   output reg                      pready,
   output reg                      pslverr,
   input  wire                     conv_req,
   input  wire [`ADCSQ_RES_W-1:0]  analog_sample,
   input  wire                     ext_result_wr,
   input  wire [`ADCSQ_RES_W-1:0]  ext_result,
   output reg                      sample_on_r,
   output reg                      bw_precharge_r,
   output reg                      irq
);
   localparam S_OFF    = 3'd0;
   localparam S_STBY   = 3'd1;
   localparam S_WAKE   = 3'd2;
   localparam S_WAIT   = 3'd3;
   localparam S_CONV   = 3'd4;
   localparam S_IDLE   = 3'd5;

   localparam [15:0] WAIT_M1 = `ADCSQ_WAIT_CYC - 1;
   localparam [15:0] WAKE_M1 = WAKE_CYC - 1;
   localparam [15:0] CONV_M1 = `ADCSQ_CONV_CYC - 1;
   localparam [15:0] CAL_LEN = CAL_CYC;
   localparam [2:0]  GAP_M1  = `ADCSQ_GLOB_GAP - 1;

   reg  [31:0] ancfg_r;
   reg  [31:0] arbcfg_r;
   reg  [31:0] bwcfg_r;
   reg  [`ADCSQ_IRQ_W-1:0] istat_r;
   reg  [`ADCSQ_IRQ_W-1:0] imask_r;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [15:0] cnt_r;
   reg  [15:0] cnt_nxt;
   reg  [15:0] cal_cnt_r;
   reg         cal_busy_r;
   reg         stby_one_r;
   reg  [`ADCSQ_RES_W-1:0] glob_r;
   reg  [2:0]  glob_gap_r;
   reg         glob_bad_r;
   reg         bw_flag_r;
   reg  [`ADCSQ_RES_W-1:0] last_r;
   reg         req_pend_r;
   reg         res_done;
   reg         bw_hit;

   wire        wr_en    = psel & penable & pwrite & pready;
   wire        rd_en    = psel & penable & ~pwrite & pready;
   wire        idle_precharge_enable      = ancfg_r[`ADCSQ_ANCFG_IPE];
   wire        slow     = ancfg_r[`ADCSQ_ANCFG_SLOW];
   wire        enabled  = arbcfg_r[`ADCSQ_ARBCFG_EN];
   wire [`ADCSQ_RES_W-1:0] bw_thr = bwcfg_r[`ADCSQ_BW_THR_LSB +: `ADCSQ_RES_W];
   wire [`ADCSQ_RES_W-1:0] fifo_rdata;
   wire        fifo_valid;
   wire        fifo_ovr;
   wire        fifo_drop;
   wire        fifo_rd  = rd_en & (paddr == `ADCSQ_A_FIFO) & fifo_valid;
   wire [`ADCSQ_IRQ_W-1:0] ev;

   // Conversion results feed the chained result stages.
   adcsq_fifo u_fifo
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .wr        (res_done),
      .wdata     (analog_sample),
      .rd        (fifo_rd),
      .rdata     (fifo_rdata),
      .out_valid (fifo_valid),
      .overwrite (fifo_ovr),
      .dropped   (fifo_drop)
   );

   // Wakeup sequencer: standby exit, optional waiting phase, sampling, conversion.
   always @*
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      res_done  = 1'b0;
      case (state_r)
         S_OFF:
            if (enabled)
               state_nxt = slow ? S_STBY : S_IDLE;
         S_STBY:
            if (!enabled)
               state_nxt = S_OFF;
            else if (req_pend_r)
            begin
               // Leaving standby after a single cycle needs no waiting phase.
               if (!idle_precharge_enable && !stby_one_r)
               begin
                  state_nxt = S_WAIT;
                  cnt_nxt   = WAIT_M1;
               end
               else if (stby_one_r)
               begin
                  state_nxt = S_CONV;
                  cnt_nxt   = CONV_M1;
               end
               else
               begin
                  state_nxt = S_WAKE;
                  cnt_nxt   = WAKE_M1;
               end
            end
         S_WAIT:
            if (cnt_r == 16'h0000)
            begin
               state_nxt = S_WAKE;
               cnt_nxt   = WAKE_M1;
            end
            else
               cnt_nxt = cnt_r - 16'h0001;
         S_WAKE:
            if (cnt_r == 16'h0000)
            begin
               state_nxt = S_CONV;
               cnt_nxt   = CONV_M1;
            end
            else
               cnt_nxt = cnt_r - 16'h0001;
         S_CONV:
            if (cnt_r == 16'h0000)
            begin
               res_done  = 1'b1;
               state_nxt = slow ? S_STBY : S_IDLE;
            end
            else
               cnt_nxt = cnt_r - 16'h0001;
         S_IDLE:
            if (!enabled)
               state_nxt = S_OFF;
            else if (slow)
               state_nxt = S_STBY;
            else if (req_pend_r && !cal_busy_r)
            begin
               state_nxt = S_CONV;
               cnt_nxt   = CONV_M1;
            end
         default:
            state_nxt = S_OFF;
      endcase
   end

   // Broken wire compare against ground or reference threshold.
   always @*
   begin
      if (bwcfg_r[`ADCSQ_BW_REF])
         bw_hit = analog_sample >= bw_thr;
      else
         bw_hit = analog_sample <= bw_thr;
   end

   assign ev = {cal_busy_r & (cal_cnt_r == 16'h0001), res_done & bw_hit
                & bwcfg_r[`ADCSQ_BW_EN], fifo_drop, fifo_ovr, res_done};

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r        <= S_OFF;
         cnt_r          <= 16'h0000;
         stby_one_r     <= 1'b0;
         req_pend_r     <= 1'b0;
         last_r         <= {`ADCSQ_RES_W{1'b0}};
         sample_on_r    <= 1'b0;
         bw_precharge_r <= 1'b0;
         bw_flag_r      <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         // Marks a standby stay of only one cycle.
         stby_one_r <= (state_r != S_STBY) & (state_nxt == S_STBY);
         if (conv_req && enabled)
            req_pend_r <= 1'b1;
         else if (state_nxt == S_CONV && state_r != S_CONV)
            req_pend_r <= 1'b0;
         sample_on_r    <= (state_nxt == S_WAKE) | (state_nxt == S_CONV);
         bw_precharge_r <= bwcfg_r[`ADCSQ_BW_EN] & (state_nxt == S_CONV)
                           & (state_r != S_CONV);
         if (res_done)
         begin
            last_r    <= analog_sample;
            bw_flag_r <= bw_hit & bwcfg_r[`ADCSQ_BW_EN];
         end
      end
   end

   // Calibration runs for a fixed time after the start command.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cal_busy_r <= 1'b0;
         cal_cnt_r  <= 16'h0000;
      end
      else if (wr_en && paddr == `ADCSQ_A_GLOBAL_CONFIG_REGISTER && pwdata == 32'h8000_0000)
      begin
         cal_busy_r <= 1'b1;
         cal_cnt_r  <= CAL_LEN;
      end
      else if (cal_busy_r)
      begin
         cal_cnt_r <= cal_cnt_r - 16'h0001;
         if (cal_cnt_r == 16'h0001)
            cal_busy_r <= 1'b0;
      end
   end

   // Shared result register flags writes closer than the minimum spacing.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         glob_r     <= {`ADCSQ_RES_W{1'b0}};
         glob_gap_r <= 3'd0;
         glob_bad_r <= 1'b0;
      end
      else
      begin
         if (glob_gap_r != 3'd0)
            glob_gap_r <= glob_gap_r - 3'd1;
         if (ext_result_wr)
         begin
            glob_r     <= ext_result;
            glob_gap_r <= GAP_M1;
            if (glob_gap_r != 3'd0)
               glob_bad_r <= 1'b1;
         end
         else if (rd_en && paddr == `ADCSQ_A_SHARED_RESULT_REGISTER)
            glob_bad_r <= 1'b0;
      end
   end

   // APB slave; every access completes in its first access cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ancfg_r  <= 32'h0000_0000;
         arbcfg_r <= 32'h0000_0000;
         bwcfg_r  <= 32'h0000_0000;
         imask_r  <= {`ADCSQ_IRQ_W{1'b0}};
         istat_r  <= {`ADCSQ_IRQ_W{1'b0}};
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         irq      <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         irq     <= |(istat_r & imask_r);
         // A read clears only the bits it returned, and a new event wins, so none is lost.
         if (rd_en && paddr == `ADCSQ_A_IRQ_STAT)
            istat_r <= (istat_r & ~prdata[`ADCSQ_IRQ_W-1:0]) | ev;
         else
            istat_r <= istat_r | ev;
         if (wr_en)
            case (paddr)
               `ADCSQ_A_ANCFG:    ancfg_r  <= pwdata;
               `ADCSQ_A_ARBCFG:   arbcfg_r <= pwdata;
               `ADCSQ_A_BWCFG:    bwcfg_r  <= pwdata;
               `ADCSQ_A_IRQ_MASK: imask_r  <= pwdata[`ADCSQ_IRQ_W-1:0];
               default:           ;
            endcase
         // The error is decided in the setup cycle so that it stands with pready.
         if (psel && !penable && pwrite)
            case (paddr)
               `ADCSQ_A_ANCFG, `ADCSQ_A_ARBCFG, `ADCSQ_A_BWCFG, `ADCSQ_A_GLOBAL_CONFIG_REGISTER,
               `ADCSQ_A_IRQ_MASK: pslverr <= 1'b0;
               default:           pslverr <= 1'b1;
            endcase
         if (psel && !penable && !pwrite)
            case (paddr)
               `ADCSQ_A_ANCFG:    prdata <= ancfg_r;
               `ADCSQ_A_ARBCFG:   prdata <= {arbcfg_r[31:1], arbcfg_r[0]};
               `ADCSQ_A_GLOBAL_CONFIG_REGISTER:  prdata <= {cal_busy_r, 31'h0000_0000};
               `ADCSQ_A_BWCFG:    prdata <= bwcfg_r;
               `ADCSQ_A_STATUS:   prdata <= {24'h00_0000, glob_bad_r, bw_flag_r,
                                             fifo_valid, cal_busy_r, 1'b0, state_r};
               `ADCSQ_A_IRQ_STAT: prdata <= {27'h000_0000, istat_r};
               `ADCSQ_A_IRQ_MASK: prdata <= {27'h000_0000, imask_r};
               `ADCSQ_A_FIFO:     prdata <= {fifo_valid, 19'h0_0000, fifo_rdata};
               `ADCSQ_A_SHARED_RESULT_REGISTER:  prdata <= {20'h0_0000, glob_r};
               `ADCSQ_A_SAMPLE:   prdata <= {20'h0_0000, last_r};
               default:           prdata <= 32'h0000_0000;
            endcase
      end
   end
endmodule

//--- verification/adcsq_chk.sv
// Port checker for the converter sequencing block, bound to its top module.
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_chk
#(
   parameter WAKE_CYC = 4,
   parameter CAL_CYC  = 4
)
(
   input wire                     pclk,
   input wire                     presetn,
   input wire                     psel,
   input wire                     penable,
   input wire                     pwrite,
   input wire [11:0]              paddr,
   input wire [31:0]              pwdata,
   input wire [31:0]              prdata,
   input wire                     pready,
   input wire                     pslverr,
   input wire                     conv_req,
   input wire [`ADCSQ_RES_W-1:0]  analog_sample,
   input wire                     ext_result_wr,
   input wire [`ADCSQ_RES_W-1:0]  ext_result,
   input wire                     sample_on_r,
   input wire                     bw_precharge_r,
   input wire                     irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   a_ready_first: assert property (setup_s |=> access_s) else $error("no answer in access");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
   a_idle_quiet: assert property (!psel |=> !pready) else $error("pready without request");
   a_err_ready: assert property (pslverr |-> access_s and pwrite) else $error("stray error");
   a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite) else $error("prdata moved");
   a_conv_min: assert property ($rose(sample_on_r) |-> sample_on_r [*8]) else $error("short conv");
   a_conv_bound: assert property ($rose(sample_on_r) |-> ##[1:1000] !sample_on_r) else $error("hang");
   a_bw_start: assert property (bw_precharge_r |-> ##[0:1] sample_on_r) else $error("stray precharge");
   a_bw_pulse: assert property (bw_precharge_r |=> !bw_precharge_r) else $error("long precharge");
endmodule
bind adcsq_top adcsq_chk #(.WAKE_CYC(WAKE_CYC), .CAL_CYC(CAL_CYC)) i_chk
(
   .pclk           (pclk),
   .presetn        (presetn),
   .psel           (psel),
   .penable        (penable),
   .pwrite         (pwrite),
   .paddr          (paddr),
   .pwdata         (pwdata),
   .prdata         (prdata),
   .pready         (pready),
   .pslverr        (pslverr),
   .conv_req       (conv_req),
   .analog_sample  (analog_sample),
   .ext_result_wr  (ext_result_wr),
   .ext_result     (ext_result),
   .sample_on_r    (sample_on_r),
   .bw_precharge_r (bw_precharge_r),
   .irq            (irq)
);

//--- verification/adcsq_tb_top.sv
// Self-checking bench for the converter sequencing block.
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_tb_top;
   reg                     pclk = 1'b0;
   reg                     presetn = 1'b0;
   reg                     psel = 1'b0;
   reg                     penable = 1'b0;
   reg                     pwrite = 1'b0;
   reg  [11:0]             paddr = 12'h000;
   reg  [31:0]             pwdata = 32'h0000_0000;
   reg                     conv_req = 1'b0;
   reg  [`ADCSQ_RES_W-1:0] analog_sample = 12'h000;
   reg                     ext_result_wr = 1'b0;
   reg  [`ADCSQ_RES_W-1:0] ext_result = 12'h000;
   wire [31:0]             prdata;
   wire                    pready;
   wire                    pslverr;
   wire                    sample_on_r;
   wire                    bw_precharge_r;
   wire                    irq;
   integer                 n_mismatch = 0;
   integer                 checked = 0;
   integer                 len_a;
   integer                 len_b;
   integer                 i;
   reg  [31:0]             r;
   reg                     e;
   reg                     bw_seen;
   always #50 pclk = ~pclk;
   adcsq_top #(.WAKE_CYC(4), .CAL_CYC(4)) i_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_req(conv_req), .analog_sample(analog_sample), .ext_result_wr(ext_result_wr),
      .ext_result(ext_result), .sample_on_r(sample_on_r), .bw_precharge_r(bw_precharge_r),
      .irq(irq)
   );
   task stop_test;
      begin
         if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Called right after a rising edge; the request holds until pready is sampled high.
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // One idle edge keeps the next setup from driving psel twice in one step.
         @(posedge pclk);
      end
   endtask
   // The length runs from the request to the end of conversion, so any wait phase counts.
   // Only the watchdog ends a conversion that never finishes.
   task conv(input [11:0] s, output integer len);
      reg seen_on;
      begin
         analog_sample <= s;
         conv_req <= 1'b1;
         @(posedge pclk);
         conv_req <= 1'b0;
         len = 1;
         seen_on = 1'b0;
         bw_seen = 1'b0;
         while (!(seen_on && sample_on_r === 1'b0))
         begin
            seen_on = seen_on | (sample_on_r === 1'b1);
            bw_seen = bw_seen | (bw_precharge_r === 1'b1);
            len = len + 1;
            @(posedge pclk);
         end
         repeat (4) @(posedge pclk);
      end
   endtask
   initial
   begin
      repeat (50000) @(posedge pclk);
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({pready, irq, sample_on_r}, 32'h0000_0000);
      apb(1, `ADCSQ_A_ANCFG, 32'h0000_0003);
      apb(0, `ADCSQ_A_ANCFG, 32'h0000_0000);
      chk(r, 32'h0000_0003);
      apb(0, 12'h0FC, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      chk(e, 32'h0000_0000);
      apb(1, 12'h0FC, 32'h0000_0001);
      chk(e, 32'h0000_0001);
      apb(1, `ADCSQ_A_STATUS, 32'h0000_0001);
      chk(e, 32'h0000_0001);
      apb(1, `ADCSQ_A_ARBCFG, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      apb(1, `ADCSQ_A_GLOBAL_CONFIG_REGISTER, 32'h0000_0001);
      apb(0, `ADCSQ_A_GLOBAL_CONFIG_REGISTER, 32'h0000_0000);
      chk(r[31], 32'h0000_0000);
      apb(1, `ADCSQ_A_GLOBAL_CONFIG_REGISTER, 32'h8000_0000);
      apb(0, `ADCSQ_A_GLOBAL_CONFIG_REGISTER, 32'h0000_0000);
      chk(r[31], 32'h0000_0001);
      repeat (20) @(posedge pclk);
      apb(0, `ADCSQ_A_GLOBAL_CONFIG_REGISTER, 32'h0000_0000);
      chk(r[31], 32'h0000_0000);
      apb(0, `ADCSQ_A_IRQ_STAT, 32'h0000_0000);
      chk(r, 32'h0000_0010);
      apb(0, `ADCSQ_A_IRQ_STAT, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      apb(1, `ADCSQ_A_ARBCFG, 32'h0000_0001);
      apb(1, `ADCSQ_A_ANCFG, 32'h0000_0001);
      apb(1, `ADCSQ_A_IRQ_MASK, 32'h0000_0001);
      conv(12'h123, len_a);
      chk(irq, 32'h0000_0001);
      apb(0, `ADCSQ_A_SAMPLE, 32'h0000_0000);
      chk(r, 32'h0000_0123);
      apb(0, `ADCSQ_A_FIFO, 32'h0000_0000);
      chk(r, 32'h8000_0123);
      apb(0, `ADCSQ_A_IRQ_STAT, 32'h0000_0000);
      chk(r, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk(irq, 32'h0000_0000);
      apb(0, `ADCSQ_A_FIFO, 32'h0000_0000);
      chk(r[31], 32'h0000_0000);
      apb(1, `ADCSQ_A_IRQ_MASK, 32'h0000_0000);
      for (i = 0; i < 6; i = i + 1)
         conv(12'h100 + i[11:0], len_a);
      chk(irq, 32'h0000_0000);
      apb(0, `ADCSQ_A_IRQ_STAT, 32'h0000_0000);
      chk(r[1], 32'h0000_0001);
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(0, `ADCSQ_A_FIFO, 32'h0000_0000);
         chk(r, 32'h8000_0100 + ((i == 3) ? 5 : i));
      end
      apb(0, `ADCSQ_A_FIFO, 32'h0000_0000);
      chk(r[31], 32'h0000_0000);
      apb(1, `ADCSQ_A_BWCFG, 32'h0000_1991);
      conv(12'h010, len_a);
      chk(bw_seen, 32'h0000_0001);
      apb(0, `ADCSQ_A_STATUS, 32'h0000_0000);
      chk(r[6], 32'h0000_0001);
      apb(0, `ADCSQ_A_IRQ_STAT, 32'h0000_0000);
      chk(r[3], 32'h0000_0001);
      apb(1, `ADCSQ_A_BWCFG, 32'h0000_0000);
      apb(1, `ADCSQ_A_ANCFG, 32'h0000_0002);
      repeat (6) @(posedge pclk);
      conv(12'h020, len_a);
      apb(1, `ADCSQ_A_ANCFG, 32'h0000_0003);
      repeat (6) @(posedge pclk);
      conv(12'h030, len_b);
      chk(len_b >= 12, 32'h0000_0001);
      chk(len_a >= len_b + 256, 32'h0000_0001);
      // A request still pending as standby is entered leaves it after one cycle.
      apb(1, `ADCSQ_A_ANCFG, 32'h0000_0002);
      conv_req <= 1'b1;
      @(posedge pclk);
      while (sample_on_r !== 1'b1)
         @(posedge pclk);
      while (sample_on_r === 1'b1)
         @(posedge pclk);
      len_a = 0;
      while (sample_on_r !== 1'b1)
      begin
         len_a = len_a + 1;
         @(posedge pclk);
      end
      conv_req <= 1'b0;
      chk(len_a, 32'h0000_0001);
      ext_result <= 12'hABC;
      ext_result_wr <= 1'b1;
      @(posedge pclk);
      ext_result_wr <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(0, `ADCSQ_A_SHARED_RESULT_REGISTER, 32'h0000_0000);
      chk(r[11:0], 32'h0000_0ABC);
      ext_result_wr <= 1'b1;
      @(posedge pclk);
      ext_result_wr <= 1'b0;
      @(posedge pclk);
      ext_result_wr <= 1'b1;
      @(posedge pclk);
      ext_result_wr <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(0, `ADCSQ_A_STATUS, 32'h0000_0000);
      chk(r[7], 32'h0000_0001);
      stop_test;
   end
endmodule
